// file: design/bsfa_boot_spi_flash_access.sv
// file: serial flash sequencer with boot unprotect, write enable polling and shared bus
// Function
// - fast read: 0x0b, address, dummy, stream
// - status read 0x05, write 0x01, enable 0x06
// - page program: 0x02, address, data back-to-back
// - sector erase 0x20 plus address, chip 0xc7
// - reset low tri-states clock, data, flash select
// - pmic select stays driven during reset
// - flash programmable via relay or external programmer
// - one master shares lines across two slaves
// - serial clock runs at most 36 MHz
// - one select per slave, one at once
// - i2c relay ports run at 100 kHz
// - boot: enable, poll latch, write status zero
// - enable and poll latch before program/erase
`timescale 1ns/1ns
module bsfa_boot_spi_flash_access #(
  parameter int FIFO_DEPTH = 16 // program data buffer depth
) (
  input wire logic clk_i, // 125 MHz system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic system_reset_n_i, // pin reset, low tri-states flash pins
  input wire logic req_valid_i, // command request (relayed host or boot)
  output logic req_ready_o, // sequencer idle and boot done
  input wire logic [2:0] req_cmd_i, // bsfa_cmd_t code
  input wire logic [23:0] req_addr_i, // flash byte address
  input wire logic [15:0] req_len_i, // bytes to read or program, 0 means 1
  input wire logic pmic_sel_i, // address power device instead of flash
  input wire logic [7:0] pmic_data_i, // byte sent to power device twice in one frame
  input wire logic [7:0] wr_data_i, // program data into buffer
  input wire logic wr_valid_i, // program data valid
  output logic wr_ready_o, // program buffer has room
  output logic [7:0] rd_data_o, // read or status byte
  output logic rd_valid_o, // one-cycle pulse per byte received in ST_MAIN data phase, none for polls or dummy
  output logic boot_done_o, // boot unprotect finished
  output logic busy_o, // a sequence is running
  output logic flash_bus_clock_o, // serial clock
  output logic flash_bus_clock_oe_o, // clock enable, low in reset
  output logic flash_bus_mosi_o, // serial data out
  output logic flash_bus_mosi_oe_o, // data enable, low in reset
  input wire logic flash_bus_miso_i, // shared serial data in
  output logic flash_select_n_o, // flash select, active low
  output logic flash_select_n_oe_o, // flash select enable, low in reset
  output logic pmic_select_n_o // power device select, always driven
);
  typedef enum logic [3:0] {
    ST_BOOT, ST_IDLE, ST_WRITE_ENABLE_COMMAND, ST_POLL_WEL, ST_MAIN, ST_POLL_BUSY, ST_GAP, ST_DONE
  } bsfa_state_t;
  // byte phases within a frame
  typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_DUMMY, PH_TX, PH_RX} bsfa_phase_t;

  bsfa_state_t state, next_state; // sequence state
  bsfa_state_t after_gap, next_after_gap; // state after the select gap
  bsfa_phase_t phase, next_phase; // byte phase
  logic frame, next_frame; // select asserted
  logic [2:0] cmd, next_cmd; // latched command
  logic [23:0] addr, next_addr; // latched address
  logic [15:0] left, next_left; // data bytes remaining
  logic use_pmic, next_use_pmic; // frame targets power device
  logic [7:0] pbyte, next_pbyte; // power device byte
  logic [7:0] op, next_op; // opcode of current frame
  logic [7:0] sh, next_sh; // shift register
  logic [2:0] bitn, next_bitn; // bit index
  logic [1:0] abyte, next_abyte; // address byte index
  logic sck, next_sck; // clock level
  logic [7:0] div, next_div; // half period / gap counter
  logic boot_done, next_boot_done;
  logic [7:0] rdat, next_rdat;
  logic rval, next_rval;
  logic [7:0] fifo_data; // head of program buffer
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_flush;

  // sector erase needs an address and a program and erase needs the latch
  function automatic logic needs_wel(input logic [2:0] c);
    return c == 3'(bsfa_pkg::BSFA_CMD_PROGRAM) || c == 3'(bsfa_pkg::BSFA_CMD_SECTOR_ERASE)
        || c == 3'(bsfa_pkg::BSFA_CMD_CHIP_ERASE);
  endfunction : needs_wel

  // program data buffer, back-pressure reaches the data source
  bsfa_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(fifo_flush),
    .in_data_i(wr_data_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  assign fifo_flush = (state == ST_IDLE) && !req_valid_i;
  assign req_ready_o = (state == ST_IDLE);
  assign busy_o = (state != ST_IDLE);
  assign boot_done_o = boot_done;
  assign rd_data_o = rdat;
  assign rd_valid_o = rval;
  assign flash_bus_clock_oe_o = system_reset_n_i;
  assign flash_bus_mosi_oe_o = system_reset_n_i;
  assign flash_select_n_oe_o = system_reset_n_i;
  assign flash_bus_clock_o = sck;
  assign flash_bus_mosi_o = sh[7];
  assign flash_select_n_o = !(frame && !use_pmic);
  assign pmic_select_n_o = !(frame && use_pmic);
  // program byte is popped as it is loaded into the shifter, so no byte goes out twice
  assign fifo_pop = frame && sck && div == '0 && bitn == bsfa_pkg::BITS_LAST && !use_pmic && fifo_valid
      && ((phase == PH_TX && left > 16'h0001)
      || (phase == PH_ADDR && op == bsfa_pkg::OP_PAGE_PROGRAM && abyte == 2'(bsfa_pkg::ADDR_BYTES - 3'h1)));

  // sequencer and serial engine next-state logic
  always_comb begin
    logic edge_due;
    logic byte_end;
    edge_due = 1'b0;
    byte_end = 1'b0;
    next_state = state; next_after_gap = after_gap; next_phase = phase; next_frame = frame;
    next_cmd = cmd; next_addr = addr; next_left = left; next_use_pmic = use_pmic;
    next_pbyte = pbyte; next_op = op; next_sh = sh; next_bitn = bitn; next_abyte = abyte;
    next_sck = sck; next_div = div; next_boot_done = boot_done; next_rdat = rdat; next_rval = 1'b0;
    if (frame) begin
      // half period count limits clock rate
      if (div != '0) begin
        next_div = div - 8'h01;
      end else begin
        edge_due = 1'b1;
        next_div = 8'(bsfa_pkg::SCK_HALF_CYC - 1);
      end
      if (edge_due && !sck) begin
        // rising edge: sample in (mode 0)
        next_sck = 1'b1;
        next_rdat = {rdat[6:0], flash_bus_miso_i};
      end else if (edge_due) begin
        // falling edge: shift out or finish byte
        next_sck = 1'b0;
        next_sh = {sh[6:0], 1'b0};
        next_bitn = bitn + 3'h1;
        byte_end = (bitn == bsfa_pkg::BITS_LAST);
      end
      if (byte_end) begin
        case (phase)
          PH_OP: begin
            if (use_pmic) begin
              next_phase = PH_TX; next_sh = pbyte; next_left = 16'h0000;
            end else if (op == bsfa_pkg::OP_FAST_READ || op == bsfa_pkg::OP_PAGE_PROGRAM
                || op == bsfa_pkg::OP_SECTOR_ERASE) begin
              next_phase = PH_ADDR; next_abyte = 2'h0; next_sh = addr[23:16];
            end else if (op == bsfa_pkg::OP_STATUS_READ) begin
              // status reads keep the request length for the command that follows
              next_phase = PH_RX; next_sh = 8'h00;
            end else if (op == bsfa_pkg::OP_STATUS_WRITE) begin
              next_phase = PH_TX; next_sh = bsfa_pkg::STATUS_CLEAR; next_left = 16'h0000;
            end else begin
              next_frame = 1'b0;
            end
          end
          PH_ADDR: begin
            next_abyte = abyte + 2'h1;
            if (abyte == 2'(bsfa_pkg::ADDR_BYTES - 3'h1)) begin
              if (op == bsfa_pkg::OP_FAST_READ) begin
                next_phase = PH_DUMMY; next_sh = 8'h00;
              end else if (op == bsfa_pkg::OP_PAGE_PROGRAM) begin
                next_phase = PH_TX; next_sh = fifo_data;
              end else begin
                next_frame = 1'b0;
              end
            end else begin
              next_sh = (abyte == 2'h0) ? addr[15:8] : addr[7:0];
            end
          end
          PH_DUMMY: begin
            next_phase = PH_RX;
          end
          PH_TX: begin
            if (left <= 16'h0001 || use_pmic) begin
              next_frame = 1'b0;
            end else begin
              next_left = left - 16'h0001; next_sh = fifo_data;
            end
          end
          default: begin
            next_rval = (state == ST_MAIN); // internal polls are not handed out
            if (left <= 16'h0001 || op == bsfa_pkg::OP_STATUS_READ) begin
              next_frame = 1'b0;
            end else begin
              next_left = left - 16'h0001;
            end
          end
        endcase
        if (next_frame == 1'b0) begin
          next_state = ST_GAP;
          next_div = 8'(bsfa_pkg::CS_HIGH_CYC);
        end
      end
    end else begin
      case (state)
        ST_BOOT: begin
          next_cmd = 3'(bsfa_pkg::BSFA_CMD_STATUS_READ);
          next_state = ST_WRITE_ENABLE_COMMAND;
        end
        ST_IDLE: begin
          if (req_valid_i) begin
            next_cmd = req_cmd_i; next_addr = req_addr_i; next_use_pmic = pmic_sel_i;
            next_pbyte = pmic_data_i; next_left = (req_len_i == 16'h0000) ? 16'h0001 : req_len_i;
            if (pmic_sel_i) begin
              next_op = pmic_data_i; next_state = ST_MAIN;
            end else if (needs_wel(req_cmd_i)) begin
              // write enable precedes program or erase
              next_state = ST_WRITE_ENABLE_COMMAND;
            end else begin
              next_state = ST_MAIN;
            end
          end
        end
        ST_WRITE_ENABLE_COMMAND: begin
          next_op = bsfa_pkg::OP_WRITE_ENABLE; next_use_pmic = 1'b0; next_after_gap = ST_POLL_WEL;
        end
        ST_POLL_WEL: begin
          next_op = bsfa_pkg::OP_STATUS_READ; next_after_gap = ST_MAIN;
        end
        ST_MAIN: begin
          case (cmd)
            3'(bsfa_pkg::BSFA_CMD_READ): next_op = bsfa_pkg::OP_FAST_READ;
            3'(bsfa_pkg::BSFA_CMD_PROGRAM): next_op = bsfa_pkg::OP_PAGE_PROGRAM;
            3'(bsfa_pkg::BSFA_CMD_SECTOR_ERASE): next_op = bsfa_pkg::OP_SECTOR_ERASE;
            3'(bsfa_pkg::BSFA_CMD_CHIP_ERASE): next_op = bsfa_pkg::OP_CHIP_ERASE;
            default: next_op = boot_done ? bsfa_pkg::OP_STATUS_READ : bsfa_pkg::OP_STATUS_WRITE;
          endcase
          if (use_pmic) next_op = pbyte;
          next_after_gap = (needs_wel(cmd) || !boot_done) && !use_pmic ? ST_POLL_BUSY : ST_DONE;
        end
        ST_POLL_BUSY: begin
          // poll busy after program or erase
          next_op = bsfa_pkg::OP_STATUS_READ; next_after_gap = ST_DONE;
        end
        ST_GAP: begin
          // deselect time, then decide on the status read result
          if (div != '0) begin
            next_div = div - 8'h01;
          end else if (op == bsfa_pkg::OP_STATUS_READ && after_gap == ST_MAIN
              && !rdat[bsfa_pkg::WRITE_ENABLE_LATCH_BIT]) begin
            next_state = ST_POLL_WEL;
          end else if (op == bsfa_pkg::OP_STATUS_READ && after_gap == ST_DONE && state == ST_GAP
              && (cmd != 3'(bsfa_pkg::BSFA_CMD_STATUS_READ) || !boot_done) && rdat[bsfa_pkg::FLASH_BUSY_BIT]) begin
            next_state = ST_POLL_BUSY;
          end else begin
            next_state = after_gap;
          end
        end
        default: begin
          // ST_DONE: boot completes after status write settles
          next_boot_done = 1'b1;
          next_state = ST_IDLE;
        end
      endcase
      // start a frame from the enable, latch poll, main and busy poll states; the pmic opcode loaded in ST_IDLE waits for ST_MAIN
      if (state == ST_WRITE_ENABLE_COMMAND || state == ST_POLL_WEL || state == ST_MAIN || state == ST_POLL_BUSY) begin
        next_frame = 1'b1; next_phase = PH_OP; next_bitn = 3'h0; next_sck = 1'b0;
        next_sh = next_op; next_div = 8'(bsfa_pkg::SCK_HALF_CYC - 1);
      end
    end
  end

  // register all sequencer state
  always_ff @(posedge clk_i) begin
    if (reset_i || !system_reset_n_i) begin
      state <= ST_BOOT; after_gap <= ST_IDLE; phase <= PH_OP; frame <= 1'b0;
      cmd <= 3'h0; addr <= 24'h000000; left <= 16'h0000; use_pmic <= 1'b0; pbyte <= 8'h00;
      op <= 8'h00; sh <= 8'h00; bitn <= 3'h0; abyte <= 2'h0; sck <= 1'b0; div <= 8'h00;
      boot_done <= 1'b0; rdat <= 8'h00; rval <= 1'b0;
    end else begin
      state <= next_state; after_gap <= next_after_gap; phase <= next_phase; frame <= next_frame;
      cmd <= next_cmd; addr <= next_addr; left <= next_left; use_pmic <= next_use_pmic;
      pbyte <= next_pbyte; op <= next_op; sh <= next_sh; bitn <= next_bitn; abyte <= next_abyte;
      sck <= next_sck; div <= next_div; boot_done <= next_boot_done; rdat <= next_rdat; rval <= next_rval;
    end
  end
endmodule : bsfa_boot_spi_flash_access

// file: design/bsfa_fifo.sv
// file: synchronous valid/ready fifo used for the program data path
`timescale 1ns/1ns
module bsfa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic flush_i, // drop all stored words
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // room available
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // head word valid
  input wire logic out_ready_i // consumer takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic [AW-1:0] wr_ptr; // write index
  logic [AW-1:0] rd_ptr; // read index
  logic [AW:0] count; // stored words
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push; // accepted write
  logic pop; // accepted read

  // handshake flags from the occupancy
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // next pointer and count values
  always_comb begin
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
  end

  // register pointers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : bsfa_fifo

// file: design/bsfa_pkg.sv
// package: opcodes, status bit positions and timing counts for the boot flash sequencer
package bsfa_pkg;
  // flash opcodes
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  // status byte fields
  localparam int FLASH_BUSY_BIT = 0;
  localparam int WRITE_ENABLE_LATCH_BIT = 1;
  localparam int STATUS_LOCK_BIT = 7;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  // byte counts
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] DUMMY_BYTES = 3'h1;
  localparam logic [2:0] BITS_LAST = 3'h7;
  // timing: clock 125 MHz, serial clock at most 36 MHz
  localparam int CLK_MHZ = 125;
  localparam int SCK_MAX_MHZ = 36;
  // half period cycles, rounded up so the serial clock never exceeds the limit
  localparam int SCK_HALF_CYC = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  // chip select high time between frames, in ns
  localparam int CS_HIGH_NS = 200;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
  // i2c relay rate
  localparam int I2C_KHZ = 100;
  // command codes on the request port
  typedef enum logic [2:0] {
    BSFA_CMD_READ,
    BSFA_CMD_PROGRAM,
    BSFA_CMD_SECTOR_ERASE,
    BSFA_CMD_CHIP_ERASE,
    BSFA_CMD_STATUS_READ
  } bsfa_cmd_t;
endpackage : bsfa_pkg

// file: sim/bsfa_boot_spi_flash_access_tb.sv
// testbench: boot, read, status, program, erase, pmic frame and pin reset
`timescale 1ns/1ns
module bsfa_boot_spi_flash_access_tb;
  logic clk_i = 0, reset_i = 1, system_reset_n_i = 1, req_valid_i = 0, pmic_sel_i = 0, wr_valid_i = 0;
  logic [2:0] req_cmd_i = 0; // command code
  logic [23:0] req_addr_i = 0, a; // address and scratch
  logic [15:0] req_len_i = 0; // length
  logic [7:0] pmic_data_i = 0, wr_data_i = 0, rd_data_o; // byte ports
  logic req_ready_o, wr_ready_o, rd_valid_o, boot_done_o, busy_o, sck, sck_oe, mosi, mosi_oe, miso, cs_n, cs_oe, pcs;
  int fail_count = 0, checked = 0, seed = 32'hadb07697, refused = 0;
  logic [7:0] exp_q[$], pexp[$]; // expected read and program bytes
  wire sck_w = sck_oe ? sck : 1'b0; // released clock pulled low
  wire mosi_w = mosi_oe ? mosi : ~mosi; // released data shows inverse
  wire cs_w = cs_oe ? cs_n : 1'b1; // select pulled up
  bsfa_boot_spi_flash_access uut (.clk_i(clk_i), .reset_i(reset_i), .system_reset_n_i(system_reset_n_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
    .req_len_i(req_len_i), .pmic_sel_i(pmic_sel_i), .pmic_data_i(pmic_data_i), .wr_data_i(wr_data_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .boot_done_o(boot_done_o), .busy_o(busy_o), .flash_bus_clock_o(sck), .flash_bus_clock_oe_o(sck_oe),
    .flash_bus_mosi_o(mosi), .flash_bus_mosi_oe_o(mosi_oe), .flash_bus_miso_i(miso),
    .flash_select_n_o(cs_n), .flash_select_n_oe_o(cs_oe), .pmic_select_n_o(pcs));
  bsfa_flash_model model (.sck_i(sck_w), .mosi_i(mosi_w), .cs_n_i(cs_w), .miso_o(miso));
  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  task automatic summarize();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 30000);
    cmp("ready", 8'h01, 8'(req_ready_o === 1'b1));
  endtask : wait_idle
  // issue one request, feed program data, note expected read bytes
  task automatic go(input logic [2:0] c, input logic [23:0] ad, input logic [15:0] n, input logic p);
    logic [7:0] d;
    wait_idle();
    model.ops.delete();
    model.pq.delete();
    for (int i = 0; i < (n == 0 ? 1 : n); i++) if (c == 0 && !p) exp_q.push_back(8'(ad + 24'(i)) ^ 8'h5a);
    if (c == 4 && !p) exp_q.push_back(8'h00);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_addr_i <= ad;
    req_len_i <= n;
    pmic_sel_i <= p;
    pmic_data_i <= 8'($random(seed));
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    for (int i = 0; i < n && c == 1; i++) begin
      d = 8'($random(seed));
      pexp.push_back(d);
      wr_valid_i <= 1'b1;
      wr_data_i <= d;
      @(posedge clk_i);
      while (wr_ready_o !== 1'b1) begin
        refused++;
        @(posedge clk_i);
      end
    end
    wr_valid_i <= 1'b0;
    wait_idle();
  endtask : go
  // enable, latch polls, opcode, then only busy polls
  task automatic chk_seq(input logic [7:0] opc, input int minp);
    int j, t;
    j = 1;
    t = 0;
    while (j < model.ops.size() && model.ops[j] === 8'h05) j++;
    cmp("enable op", 8'h06, model.ops[0]);
    cmp("latch polls", 8'h01, 8'(j >= 3));
    cmp("command op", opc, model.ops[j]);
    for (int i = j + 1; i < model.ops.size(); i++) t += int'(model.ops[i] === 8'h05);
    cmp("busy polls", 8'h01, 8'(t >= minp && t == model.ops.size() - j - 1));
  endtask : chk_seq
  // result watcher takes the oldest note per byte
  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1) cmp("read byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, rd_data_o);
  end
  initial begin
    #720000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      wait_idle();
      cmp("boot done", 8'h01, 8'(boot_done_o));
      chk_seq(8'h01, 2);
      cmp("status len", 8'h02, 8'(model.sw_len));
      cmp("status", 8'h00, model.status);
      a = 24'($random(seed));
      go(3'h4, a, 16'h0, 1'b0);
      cmp("status op", 8'h05, model.ops[0]);
      go(3'h0, a, r ? 16'h5 : 16'h0, 1'b0);
      cmp("read op", 8'h0b, model.ops[0]);
      cmp("read addr", a[23:16], model.addr[23:16]);
      go(3'h1, a, 16'd20, 1'b0);
      chk_seq(8'h02, 3);
      cmp("fifo refused", 8'h01, 8'(refused > 0));
      cmp("program count", 8'd20, 8'(model.pq.size()));
      while (pexp.size()) cmp("program byte", pexp.pop_front(), model.pq.size() ? model.pq.pop_front() : 8'hxx);
      go(3'h2, a, 16'h0, 1'b0);
      chk_seq(8'h20, 3);
      cmp("erase addr", a[7:0], model.addr[7:0]);
      go(3'h3, a, 16'h0, 1'b0);
      chk_seq(8'hc7, 3);
      go(3'h0, a, 16'h0, 1'b1);
      cmp("pmic frame flash ops", 8'h00, 8'(model.ops.size()));
      @(posedge clk_i);
      system_reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      cmp("oe in pin reset", 8'h00, {5'h0, sck_oe, mosi_oe, cs_oe});
      cmp("pmic select", 8'h01, 8'(pcs));
      model.ops.delete();
      system_reset_n_i <= 1'b1;
    end
    wait_idle();
    cmp("left notes", 8'h00, 8'(exp_q.size()));
    summarize();
  end
endmodule : bsfa_boot_spi_flash_access_tb

// file: sim/bsfa_checker_sva.sv
// checker: port-level assertions for the boot flash sequencer
`timescale 1ns/1ns
module bsfa_checker_sva (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // sync reset
  input wire logic system_reset_n_i, // pin reset
  input wire logic req_valid_i, // request
  input wire logic req_ready_o, // idle
  input wire logic rd_valid_o, // byte pulse
  input wire logic boot_done_o, // boot finished
  input wire logic busy_o, // sequence running
  input wire logic flash_bus_clock_o, // serial clock
  input wire logic flash_bus_clock_oe_o, // clock enable
  input wire logic flash_bus_mosi_o, // data out
  input wire logic flash_bus_mosi_oe_o, // data enable
  input wire logic flash_select_n_o, // flash select
  input wire logic flash_select_n_oe_o, // flash select enable
  input wire logic pmic_select_n_o // power device select
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  int gap; // cycles the flash select has stayed high
  int next_gap; // next gap count
  // count high cycles of the flash select, saturating
  always_comb begin
    next_gap = gap;
    if (!flash_select_n_o) begin
      next_gap = 0;
    end else if (gap < 1000) begin
      next_gap = gap + 1;
    end
  end
  // gap register starts saturated so the first frame is free
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gap <= 1000;
    end else begin
      gap <= next_gap;
    end
  end
  property p_tristate;
    !system_reset_n_i |-> !flash_bus_clock_oe_o && !flash_bus_mosi_oe_o && !flash_select_n_oe_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("flash pins driven in pin reset");
  property p_pmic_idle;
    !system_reset_n_i && !$past(system_reset_n_i) |-> pmic_select_n_o;
  endproperty
  a_pmic_idle: assert property (p_pmic_idle) else $error("pmic select not held high");
  property p_one_sel;
    !pmic_select_n_o |-> flash_select_n_o;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("both selects low");
  property p_sck_high;
    $rose(flash_bus_clock_o) |-> flash_bus_clock_o[*2] ##1 !flash_bus_clock_o;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("clock high phase wrong");
  property p_sck_low;
    $fell(flash_bus_clock_o) |-> !flash_bus_clock_o[*2];
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("clock low phase short");
  property p_sck_framed;
    $changed(flash_bus_clock_o) |-> !$past(flash_select_n_o) || !$past(pmic_select_n_o);
  endproperty
  a_sck_framed: assert property (p_sck_framed) else $error("clock toggles unselected");
  property p_mode0;
    $changed(flash_bus_mosi_o) && !flash_select_n_o && !$past(flash_select_n_o) |-> !flash_bus_clock_o;
  endproperty
  a_mode0: assert property (p_mode0) else $error("data changed with clock high");
  property p_cs_gap;
    $fell(flash_select_n_o) |-> gap >= bsfa_pkg::CS_HIGH_CYC;
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select high gap short");
  property p_accept;
    req_valid_i && req_ready_o |=> !req_ready_o && busy_o;
  endproperty
  a_accept: assert property (p_accept) else $error("request not started");
  property p_ready_boot;
    req_ready_o |-> boot_done_o && !busy_o;
  endproperty
  a_ready_boot: assert property (p_ready_boot) else $error("ready before boot");
  property p_rd_pulse;
    rd_valid_o |=> !rd_valid_o[*8];
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulses too close");
endmodule : bsfa_checker_sva
bind bsfa_boot_spi_flash_access bsfa_checker_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
  .system_reset_n_i(system_reset_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .rd_valid_o(rd_valid_o), .boot_done_o(boot_done_o), .busy_o(busy_o), .flash_bus_clock_o(flash_bus_clock_o),
  .flash_bus_clock_oe_o(flash_bus_clock_oe_o), .flash_bus_mosi_o(flash_bus_mosi_o),
  .flash_bus_mosi_oe_o(flash_bus_mosi_oe_o), .flash_select_n_o(flash_select_n_o),
  .flash_select_n_oe_o(flash_select_n_oe_o), .pmic_select_n_o(pmic_select_n_o));

// file: sim/bsfa_flash_model.sv
// partner: behavioural serial flash with slow latch and busy polling
`timescale 1ns/1ns
module bsfa_flash_model (
  input wire logic sck_i, // serial clock
  input wire logic mosi_i, // data from master
  input wire logic cs_n_i, // select, active low
  output logic miso_o = 1'b0 // data to master
);
  // hold and protect tied high, not modelled
  logic [7:0] sr, tx, op, wbyte; // shift in, shift out, opcode, status write byte
  logic [7:0] status = 8'h9c; // protection starts on
  logic [23:0] addr; // captured address
  int bits, nb, polls, sw_len; // bit and byte counts, busy polls left, status write length
  logic wen_pend = 1'b0; // enable seen, latch shows one poll later
  logic [7:0] ops[$], pq[$]; // opcodes and program bytes seen
  // frame start
  always @(negedge cs_n_i) begin
    bits = 0;
    nb = 0;
  end
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      sr = {sr[6:0], mosi_i};
      bits++;
      if (bits == 8) begin
        bits = 0;
        if (nb == 0) begin
          op = sr;
          ops.push_back(sr);
        end else if (nb < 4 && (op == 8'h0b || op == 8'h02 || op == 8'h20)) begin
          addr = {addr[15:0], sr};
        end else if (op == 8'h02) begin
          pq.push_back(sr);
        end
        if (nb == 1) wbyte = sr;
        nb++;
        tx = (op == 8'h05) ? status : 8'(addr + 24'(nb - 5)) ^ 8'h5a;
      end
    end
  end
  // shift out on the falling clock
  always @(negedge sck_i) begin
    if (!cs_n_i) begin
      miso_o = tx[7];
      tx = {tx[6:0], 1'b0};
    end
  end
  always @(posedge cs_n_i) begin
    miso_o = ~miso_o;
    if (op == 8'h06) wen_pend = 1'b1;
    if (op == 8'h05 && wen_pend) begin
      status[1] = 1'b1;
      wen_pend = 1'b0;
    end else if (op == 8'h05 && polls > 0) begin
      polls--;
      status[0] = (polls != 0);
    end
    if (op == 8'h01) begin
      sw_len = nb;
      status = (wbyte & 8'hfc) | 8'h01;
      polls = 2;
    end
    if (op == 8'h02 || op == 8'h20 || op == 8'hc7) begin
      if (!status[1]) pq.delete();
      polls = status[1] ? 3 : 0;
      status[0] = status[1];
      status[1] = 1'b0;
    end
  end
endmodule : bsfa_flash_model
